/* File: logic/vir_pkg.sv */
`default_nettype none
package vir_pkg;

  localparam int NUM_CHAN = 64;
  localparam int NUM_SRC  = 64;
  localparam int CHAN_W   = 6;
  localparam int SRC_W    = 6;

  typedef logic [CHAN_W-1:0] vir_chan_t;
  typedef logic [SRC_W-1:0]  vir_src_t;
  typedef logic [NUM_SRC-1:0][CHAN_W-1:0] vir_map_t;

  // Source line positions on src_req
  localparam int SRC_ESM_HIGH     = 0;
  localparam int SRC_NMI_RSVD     = 1;
  localparam int SRC_TICK_CMP0    = 2;
  localparam int SRC_TICK_OVF0    = 6;
  localparam int SRC_TICK_OVF1    = 7;
  localparam int SRC_TICK_BASE    = 8;
  localparam int SRC_GPIO_A       = 9;
  localparam int SRC_HET_L1       = 10;
  localparam int SRC_TTU_L1       = 11;
  localparam int SRC_SPI1_L0      = 12;
  localparam int SRC_LIN_SERIAL_ONE_L0      = 13;
  localparam int SRC_ADC1_EVT     = 14;
  localparam int SRC_ADC1_SW1     = 15;
  localparam int SRC_CAN1_L0      = 16;
  localparam int SRC_AUTOBUS_L0   = 18;
  localparam int SRC_CRC          = 19;
  localparam int SRC_ESM_LOW      = 20;
  localparam int SRC_SOFT_INT     = 21;
  localparam int SRC_PERF_MON     = 22;
  localparam int SRC_GPIO_B       = 23;
  localparam int SRC_HET_L2       = 24;
  localparam int SRC_TTU_L2       = 25;
  localparam int SRC_SPI1_L1      = 26;
  localparam int SRC_LIN_SERIAL_ONE_L1      = 27;
  localparam int SRC_ADC1_SW2     = 28;
  localparam int SRC_CAN1_L1      = 29;
  localparam int SRC_ADC1_MAG     = 31;

  // Reserved source lines 17 and 30 carry nothing and are ignored
  localparam logic [NUM_SRC-1:0]  RSVD_SRC_MASK = 64'h0000_0000_4002_0000;
  // Channels 0 and 1 cannot be masked and always go out as fast requests
  localparam logic [NUM_CHAN-1:0] NMI_CHAN_MASK = 64'h0000_0000_0000_0003;

  // Reset mapping: every source line lands on the channel of its own number
  function automatic vir_map_t vir_default_map();
    vir_map_t m;
    for (int s = 0; s < NUM_SRC; s++)
    begin
      m[s] = vir_chan_t'(s);
    end
    return m;
  endfunction

  localparam vir_map_t MAP_RESET = vir_default_map();

endpackage
`default_nettype wire

/* File: logic/vir_map_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface vir_map_if;
  import vir_pkg::*;
  logic      wr_en;
  vir_src_t  wr_src;
  vir_chan_t wr_chan;
  logic      restore;
  vir_map_t  map;

  modport store (input wr_en, input wr_src, input wr_chan, input restore, output map);
  modport user  (output wr_en, output wr_src, output wr_chan, output restore, input map);
endinterface
`default_nettype wire

/* File: logic/vir_map_store.sv */
`timescale 1ns/1ps
`default_nettype none
module vir_map_store
  import vir_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   reset_n,
  vir_map_if.store    m
);

  typedef struct packed {
    vir_map_t map;
  } vir_store_s;

  vir_store_s st_q;
  vir_store_s st_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_d = st_q;
    // Restore wins over a write in the same cycle
    if (m.restore)
    begin
      st_d.map = MAP_RESET;
    end
    else if (m.wr_en)
    begin
      st_d.map[m.wr_src] = m.wr_chan;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q.map <= MAP_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign m.map = st_q.map;

endmodule // vir_map_store
`default_nettype wire

/* File: logic/vir_pri_enc.sv */
`timescale 1ns/1ps
`default_nettype none
module vir_pri_enc
  import vir_pkg::*;
#(
  parameter int N = NUM_CHAN
)(
  input  wire logic [N-1:0] req,
  output logic              valid,
  output vir_chan_t         index
);

  // Lowest set bit wins
  function automatic vir_chan_t lowest_set(input logic [N-1:0] v);
    vir_chan_t r;
    r = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = vir_chan_t'(i);
      end
    end
    return r;
  endfunction

  assign valid = |req;
  assign index = lowest_set(req);

endmodule // vir_pri_enc
`default_nettype wire

/* File: logic/vir_router.sv */
// Function
// - Sixty-four request channels; every peripheral line lands on one channel.
// - Several sources mapped to one channel share it; any raises it.
// - Each channel except 0 and 1 has its own mask bit.
// - Each channel is steered to the fast or the normal request.
// - Lower channel number has higher priority; channel 0 highest.
// - Channel 0 carries the high error interrupt; channel 1 reserved, non-maskable.
// - Channels 2 to 5 carry tick timer compares 0 to 3.
// - Tick overflows 0,1 on channels 6,7; timebase on channel 8.
// - High-end timer level 1 on channel 10, level 2 on 24.
// - Timer transfer unit level 1 on channel 11, level 2 on 25.
// - Buffered SPI one level 0 on channel 12, level 1 on 26.
// - LIN serial one level 0 on channel 13, level 1 on 27.
// - ADC one: event 14, software 1 on 15, software 2 on 28, magnitude 31.
// - CAN one level 0 on 16, level 1 on 29; channels 17, 30 reserved.
// - Automotive bus level 0 on channel 18; CRC checker on 19.
// - Low error interrupt 20, software interrupt 21, performance monitor 22.
`timescale 1ns/1ps
`default_nettype none
module vir_router
  import vir_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire logic [NUM_SRC-1:0]      src_req,
  input  wire logic [NUM_CHAN-1:0]     chan_enable,
  input  wire logic [NUM_CHAN-1:0]     chan_fast,
  input  wire logic                    map_wr_en,
  input  wire vir_pkg::vir_src_t       map_wr_src,
  input  wire vir_pkg::vir_chan_t      map_wr_chan,
  input  wire logic                    map_restore,
  input  wire vir_pkg::vir_src_t       map_rd_src,
  output vir_pkg::vir_chan_t           map_rd_chan,
  output logic [NUM_CHAN-1:0]          chan_pending,
  output logic                         fiq_req,
  output vir_pkg::vir_chan_t           fiq_chan,
  output logic                         irq_req,
  output vir_pkg::vir_chan_t           irq_chan
);
  import vir_pkg::*;

  typedef struct packed {
    logic [NUM_CHAN-1:0] pending;
    logic                fiq_req;
    vir_chan_t           fiq_chan;
    logic                irq_req;
    vir_chan_t           irq_chan;
    vir_chan_t           rd_chan;
  } vir_state_s;

  vir_state_s st_q;
  vir_state_s st_d;

  logic [NUM_SRC-1:0]  src_live;
  logic [NUM_CHAN-1:0] chan_raw;
  logic [NUM_CHAN-1:0] chan_gated;
  logic [NUM_CHAN-1:0] fast_sel;
  logic [NUM_CHAN-1:0] fiq_cand;
  logic [NUM_CHAN-1:0] irq_cand;
  logic                fiq_any;
  logic                irq_any;
  vir_chan_t           fiq_win;
  vir_chan_t           irq_win;

  vir_map_if map_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Source-to-channel map, reset to the default assignment
  assign map_bus.wr_en   = map_wr_en;
  assign map_bus.wr_src  = map_wr_src;
  assign map_bus.wr_chan = map_wr_chan;
  assign map_bus.restore = map_restore;

  // Defaults live here
  // Defaults too
  vir_map_store u_map (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .m       (map_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Channel request build-up
  always_comb
  begin
    src_live = src_req & ~RSVD_SRC_MASK;
    chan_raw = '0;
    for (int s = 0; s < NUM_SRC; s++)
    begin
      // Shared channels simply OR their sources together
      if (src_live[s])
      begin
        chan_raw[map_bus.map[s]] = 1'b1;
      end
    end
  end

  // Channels 0 and 1 ignore the mask and the steering bit
  assign chan_gated = chan_raw & (chan_enable | NMI_CHAN_MASK);
  assign fast_sel   = chan_fast | NMI_CHAN_MASK;
  assign fiq_cand   = chan_gated & fast_sel;
  assign irq_cand   = chan_gated & ~fast_sel;

  vir_pri_enc #(.N(NUM_CHAN)) u_fiq_pri (
    .req   (fiq_cand),
    .valid (fiq_any),
    .index (fiq_win)
  );

  vir_pri_enc #(.N(NUM_CHAN)) u_irq_pri (
    .req   (irq_cand),
    .valid (irq_any),
    .index (irq_win)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered answer to the core; one cycle behind the source lines
  always_comb
  begin
    st_d          = st_q;
    st_d.pending  = chan_gated;
    st_d.fiq_req  = fiq_any;
    st_d.fiq_chan = fiq_any ? fiq_win : '0;
    st_d.irq_req  = irq_any;
    st_d.irq_chan = irq_any ? irq_win : '0;
    st_d.rd_chan  = map_bus.map[map_rd_src];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign chan_pending = st_q.pending;
  assign fiq_req      = st_q.fiq_req;
  assign fiq_chan     = st_q.fiq_chan;
  assign irq_req      = st_q.irq_req;
  assign irq_chan     = st_q.irq_chan;
  assign map_rd_chan  = st_q.rd_chan;

endmodule // vir_router
`default_nettype wire

/* File: test/vir_router_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module vir_router_sva
  import vir_pkg::*;
(
  input wire logic               sys_clk,
  input wire logic               reset_n,
  input wire logic [NUM_CHAN-1:0] chan_enable,
  input wire logic [NUM_CHAN-1:0] chan_fast,
  input wire logic               map_wr_en,
  input wire vir_pkg::vir_src_t  map_wr_src,
  input wire vir_pkg::vir_chan_t map_wr_chan,
  input wire logic               map_restore,
  input wire vir_pkg::vir_src_t  map_rd_src,
  input wire vir_pkg::vir_chan_t map_rd_chan,
  input wire logic [NUM_CHAN-1:0] chan_pending,
  input wire logic               fiq_req,
  input wire vir_pkg::vir_chan_t fiq_chan,
  input wire logic               irq_req,
  input wire vir_pkg::vir_chan_t irq_chan
);
  // Steering and enables as the design saw them at the edge that made the outputs
  logic [NUM_CHAN-1:0] fst_q;
  logic [NUM_CHAN-1:0] en_q;
  always_ff @(posedge sys_clk)
  begin
    fst_q <= chan_fast | NMI_CHAN_MASK;
    en_q  <= chan_enable | NMI_CHAN_MASK;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  chk_fiq_any: assert property (fiq_req == |(chan_pending & fst_q))
    else $error("fast flag wrong");
  chk_irq_any: assert property (irq_req == |(chan_pending & ~fst_q))
    else $error("normal flag wrong");
  chk_mask_gate: assert property ((chan_pending & ~en_q) == 64'h0)
    else $error("masked channel pending");
  chk_fiq_lowest: assert property (fiq_req |-> fst_q[fiq_chan] && chan_pending[fiq_chan]
    && (chan_pending & fst_q & ((64'h1 << fiq_chan) - 64'h1)) == 64'h0)
    else $error("fast winner wrong");
  chk_irq_lowest: assert property (irq_req |-> !fst_q[irq_chan] && chan_pending[irq_chan]
    && (chan_pending & ~fst_q & ((64'h1 << irq_chan) - 64'h1)) == 64'h0)
    else $error("normal winner wrong");
  chk_fiq_idle: assert property (!fiq_req |-> fiq_chan == 6'h00)
    else $error("idle fast channel");
  chk_irq_idle: assert property (!irq_req |-> irq_chan == 6'h00)
    else $error("idle normal channel");
  chk_map_restore: assert property ($past(map_restore, 2) |-> map_rd_chan == $past(map_rd_src))
    else $error("restore lost");
  chk_map_write: assert property ($past(map_wr_en, 2) && !$past(map_restore, 2)
    && $past(map_rd_src) == $past(map_wr_src, 2) |-> map_rd_chan == $past(map_wr_chan, 2))
    else $error("map write lost");
  cov_fast: cover property (fiq_req && fiq_chan > 6'h01);
  cov_norm: cover property (irq_req);
  cov_both: cover property (fiq_req && irq_req);
endmodule // vir_router_sva
bind vir_router vir_router_sva u_sva (.sys_clk(sys_clk), .reset_n(reset_n),
  .chan_enable(chan_enable), .chan_fast(chan_fast), .map_wr_en(map_wr_en),
  .map_wr_src(map_wr_src), .map_wr_chan(map_wr_chan), .map_restore(map_restore),
  .map_rd_src(map_rd_src), .map_rd_chan(map_rd_chan), .chan_pending(chan_pending),
  .fiq_req(fiq_req), .fiq_chan(fiq_chan), .irq_req(irq_req), .irq_chan(irq_chan));
`default_nettype wire

/* File: test/vir_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vir_core_model (
  input  wire logic fiq_req,
  input  wire logic irq_req,
  input  wire logic irq_mask,
  output logic      fast_taken,
  output logic      norm_taken
);
  // Core's own mask stops only normal entries; fast entry cannot be disabled
  assign fast_taken = fiq_req;
  assign norm_taken = irq_req & ~irq_mask;
endmodule // vir_core_model
`default_nettype wire

/* File: test/vir_router_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module vir_router_test;
  import vir_pkg::*;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [63:0] src_req = '0, chan_enable = '0, chan_fast = '0, chan_pending;
  logic        map_wr_en = 1'b0, map_restore = 1'b0, irq_mask = 1'b0;
  vir_src_t    map_wr_src = '0, map_rd_src = '0;
  vir_chan_t   map_wr_chan = '0, map_rd_chan, fiq_chan, irq_chan;
  logic        fiq_req, irq_req, fast_taken, norm_taken;
  int          n_errors = 0, checks_done = 0, cyc = 0;
  always #50 sys_clk = ~sys_clk;
  vir_router DUT (.sys_clk(sys_clk), .reset_n(reset_n), .src_req(src_req),
    .chan_enable(chan_enable), .chan_fast(chan_fast), .map_wr_en(map_wr_en),
    .map_wr_src(map_wr_src), .map_wr_chan(map_wr_chan), .map_restore(map_restore),
    .map_rd_src(map_rd_src), .map_rd_chan(map_rd_chan), .chan_pending(chan_pending),
    .fiq_req(fiq_req), .fiq_chan(fiq_chan), .irq_req(irq_req), .irq_chan(irq_chan));
  vir_core_model core (.fiq_req(fiq_req), .irq_req(irq_req), .irq_mask(irq_mask),
    .fast_taken(fast_taken), .norm_taken(norm_taken));
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_errors++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Results land on the same edge that takes the inputs, so look just past it
  task automatic drive(input logic [63:0] s, input logic [63:0] e, input logic [63:0] f,
                       input vir_src_t r);
    @(posedge sys_clk);
    src_req <= s;
    chan_enable <= e;
    chan_fast <= f;
    map_rd_src <= r;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wmap(input vir_src_t s, input vir_chan_t c, input logic r);
    @(posedge sys_clk);
    map_wr_en <= 1'b1;
    map_wr_src <= s;
    map_wr_chan <= c;
    map_restore <= r;
    map_rd_src <= s;
    @(posedge sys_clk);
    map_wr_en <= 1'b0;
    map_restore <= 1'b0;
  endtask
  task automatic t_defaults();
    logic [63:0] exp;
    for (int s = 0; s < 64; s++)
    begin
      exp = (s == 17 || s == 30) ? 64'h0 : 64'h1 << s;
      drive(64'h1 << s, '1, 64'h0, vir_src_t'(s));
      `CHK(chan_pending, exp)
      `CHK(irq_req, 1'(s > 1 && exp != 0))
      `CHK(map_rd_chan, vir_chan_t'(s))
      `CHK(fiq_req, 1'(s < 2))
    end
  endtask
  task automatic t_prio();
    drive(64'h0000_0100_0000_0020, '1, 64'h0, '0);
    `CHK(irq_chan, 6'h05)
    drive(64'h0000_0100_0000_0024, '1, 64'h0000_0100_0000_0000, '0);
    `CHK({fiq_chan, irq_chan}, {6'h28, 6'h02})
    irq_mask <= 1'b1;
    #1;
    `CHK({fast_taken, norm_taken}, 2'b10)
    irq_mask <= 1'b0;
  endtask
  task automatic t_mask();
    drive(64'h3, 64'h0, 64'h0, '0);
    `CHK({chan_pending, fiq_req, irq_req}, {64'h3, 1'b1, 1'b0})
    drive(64'h23, ~64'h20, 64'h0, '0);
    `CHK(chan_pending, 64'h3)
    `CHK({fiq_req, fiq_chan, irq_req}, {1'b1, 6'h00, 1'b0})
  endtask
  task automatic t_remap();
    wmap(6'd9, 6'h28, 1'b0);
    wmap(6'd23, 6'h28, 1'b0);
    drive(64'h200, '1, 64'h0, 6'd9);
    `CHK({chan_pending, map_rd_chan}, {64'h0000_0100_0000_0000, 6'h28})
    drive(64'h80_0000, '1, 64'h0, 6'd23);
    `CHK({chan_pending, irq_chan}, {64'h0000_0100_0000_0000, 6'h28})
    wmap(6'd9, 6'h03, 1'b1);
    drive(64'h200, '1, 64'h0, 6'd9);
    `CHK({chan_pending, map_rd_chan}, {64'h200, 6'h09})
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    `CHK({chan_pending, fiq_req, irq_req}, 66'h0)
    reset_n <= 1'b1;
    t_defaults();
    t_prio();
    t_mask();
    t_remap();
    summarize();
  end
endmodule // vir_router_test
`default_nettype wire
